// >>> rtl/artpwm_cfg.svh
// How it works
// - Counter holds while run enable is 0 and counts while it is 1.
// - Counter steps by one per prescaled timer tick, 256 steps full range.
// - Step from full scale to the reload value is an overflow and sets the flag.
// - Overflow flag stays set until software clears it in its service routine.
// - Every overflow reloads the counter from the reload register, always active.
// - Flag with interrupt enable set requests the interrupt at vector 0008H.
// - Timer keeps running in every power mode and never wakes the system.
// - Clock source select 0 picks high-speed ticks, 1 picks low-speed ticks.
// - Prescale code 000 divides by 128, halving per code, 111 divides by 1.
// - Mode bit 1 selects single pulse when set, continuous when clear.
// - Mode bit 0 with run enable set routes PWM to selected pins, otherwise pins stay GPIO.
// - Reload writes go to a holding buffer, made active at next overflow.
// - Reload sets the PWM period; output falls when counter equals duty.
// - Period starts high, returns high at overflow; changes apply at reload.
// - Duty not above reload keeps the output low for the whole period.
// - Single pulse emits one period, then PWM output enable clears itself.
// - Two channel bits gate PWM onto each pin; both clear means no PWM.
`ifndef ARTPWM_CFG_SVH
`define ARTPWM_CFG_SVH

`define ART_IDX_MODE 10'h0A0
`define ART_IDX_COUNT 10'h0A1
`define ART_IDX_RELOAD 10'h0A2
`define ART_IDX_DUTY 10'h0A3
`define ART_IDX_CTRL 10'h0A4

`define ART_MODE_RUN 7
`define ART_MODE_PRESC_HI 6
`define ART_MODE_PRESC_LO 4
`define ART_MODE_SINGLE 1
`define ART_MODE_PWM_EN 0

`define ART_CTRL_FLAG 0
`define ART_CTRL_IRQ_EN 1
`define ART_CTRL_CLK_SEL 2
`define ART_CTRL_CHAN_HI 5
`define ART_CTRL_CHAN_LO 4

`define ART_COUNT_FULL 8'hFF
`define ART_COUNT_RESET 8'h00
`define ART_PRESC_FULL 7'h7F
`define ART_IRQ_VECTOR 16'h0008
`define ART_GPIO_RESET 2'h0

`endif

// >>> rtl/artpwm_pkg.sv
package artpwm_pkg;

    typedef enum logic [1:0] {
        APB_IDLE,
        APB_ACCESS,
        APB_DONE
    } artpwm_apb_phase_t;

    typedef struct packed {
        logic [6:0] div_count;
        logic timer_tick;
    } artpwm_presc_state_t;

    typedef struct packed {
        logic [1:0] pin_out;
        logic [1:0] pin_pwm_active;
    } artpwm_pin_state_t;

    typedef struct packed {
        artpwm_apb_phase_t phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic run_enable;
        logic [2:0] prescale_select;
        logic single_pulse_select;
        logic pwm_output_enable;
        logic [7:0] count_value;
        logic [7:0] reload_hold;
        logic [7:0] reload_active;
        logic [7:0] duty_compare;
        logic [7:0] duty_active;
        logic overflow_flag;
        logic overflow_irq_enable;
        logic clock_source_select;
        logic [1:0] pwm_channel_select;
        logic run_seen;
        logic pwm_level;
        logic irq_request;
    } artpwm_state_t;

endpackage

// >>> rtl/artpwm_prescale.sv
`timescale 1ns/1ps
`include "artpwm_cfg.svh"

module artpwm_prescale #(
    parameter int STAGES = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic hosc_tick,
    input wire logic losc_tick,
    input wire logic clock_source_select,
    input wire logic [2:0] prescale_select,
    output logic timer_tick
);

    generate
        if (STAGES != 7) begin : g_bad_stages
            $error("artpwm_prescale serves exactly seven divider stages");
        end
    endgenerate

    artpwm_pkg::artpwm_presc_state_t s_reg;
    artpwm_pkg::artpwm_presc_state_t s_next;
    logic src_tick;
    logic [6:0] mask;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        src_tick = clock_source_select ? losc_tick : hosc_tick;
        mask = `ART_PRESC_FULL >> prescale_select;
        s_next = s_reg;
        s_next.timer_tick = 1'b0;
        // The divider restarts while stopped so the first period after enable is whole.
        if (!run) begin
            s_next.div_count = 7'h00;
        end else if (src_tick) begin
            s_next.div_count = s_reg.div_count + 7'h01;
            s_next.timer_tick = ((s_reg.div_count & mask) == mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign timer_tick = s_reg.timer_tick;

endmodule

// >>> rtl/artpwm_pin_mux.sv
`timescale 1ns/1ps
`include "artpwm_cfg.svh"

module artpwm_pin_mux #(
    parameter int CHANNELS = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwm_level,
    input wire logic route_enable,
    input wire logic [1:0] pwm_channel_select,
    input wire logic [1:0] gpio_out,
    output logic [1:0] pin_out,
    output logic [1:0] pin_pwm_active
);

    generate
        if (CHANNELS != 2) begin : g_bad_channels
            $error("artpwm_pin_mux serves exactly two channels");
        end
    endgenerate

    artpwm_pkg::artpwm_pin_state_t s_reg;
    artpwm_pkg::artpwm_pin_state_t s_next;
    logic [1:0] active;
    logic [1:0] level;

    ////////////////////////////////////////////////////////////////////////////////

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            assign active[ch] = route_enable & pwm_channel_select[ch];
            assign level[ch] = active[ch] ? pwm_level : gpio_out[ch];
        end
    endgenerate

    always_comb begin
        s_next = s_reg;
        s_next.pin_out = level;
        s_next.pin_pwm_active = active;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_out = s_reg.pin_out;
    assign pin_pwm_active = s_reg.pin_pwm_active;

endmodule

// >>> rtl/artpwm_top.sv
`timescale 1ns/1ps
`include "artpwm_cfg.svh"

module artpwm_top #(
    parameter int COUNT_WIDTH = 8,
    parameter int ADDR_WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hosc_tick,
    input wire logic losc_tick,
    input wire logic [1:0] gpio_out,
    output logic [1:0] pwm_pin_out,
    output logic [1:0] pwm_pin_active,
    output logic irq_request
);

    ////////////////////////////////////////////////////////////////////////////////

    generate
        if (COUNT_WIDTH != 8) begin : g_bad_width
            $error("artpwm_top serves only an eight-bit counter");
        end
        if (ADDR_WIDTH < 12) begin : g_bad_addr
            $error("artpwm_top needs at least twelve address bits");
        end
    endgenerate

    artpwm_pkg::artpwm_state_t s_reg;
    artpwm_pkg::artpwm_state_t s_next;
    logic timer_tick;
    logic [9:0] word_index;
    logic aligned;
    logic hit_mode;
    logic hit_count;
    logic hit_reload;
    logic hit_duty;
    logic hit_ctrl;
    logic hit_any;
    logic setup_phase;
    logic access_done;
    logic do_write;
    logic [31:0] read_word;
    logic overflow;
    logic flag_clear;
    logic [7:0] count_inc;

    ////////////////////////////////////////////////////////////////////////////////

    artpwm_prescale #(
        .STAGES(7)
    ) u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .run(s_reg.run_enable),
        .hosc_tick(hosc_tick),
        .losc_tick(losc_tick),
        .clock_source_select(s_reg.clock_source_select),
        .prescale_select(s_reg.prescale_select),
        .timer_tick(timer_tick)
    );

    artpwm_pin_mux #(
        .CHANNELS(2)
    ) u_pin_mux (
        .pclk(pclk),
        .presetn(presetn),
        .pwm_level(s_reg.pwm_level),
        .route_enable(s_reg.run_enable & s_reg.pwm_output_enable),
        .pwm_channel_select(s_reg.pwm_channel_select),
        .gpio_out(gpio_out),
        .pin_out(pwm_pin_out),
        .pin_pwm_active(pwm_pin_active)
    );

    ////////////////////////////////////////////////////////////////////////////////

    // Byte addresses are four times the register index; the two low bits must be zero.
    assign word_index = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_mode = aligned & (word_index == `ART_IDX_MODE);
    assign hit_count = aligned & (word_index == `ART_IDX_COUNT);
    assign hit_reload = aligned & (word_index == `ART_IDX_RELOAD);
    assign hit_duty = aligned & (word_index == `ART_IDX_DUTY);
    assign hit_ctrl = aligned & (word_index == `ART_IDX_CTRL);
    assign hit_any = hit_mode | hit_count | hit_reload | hit_duty | hit_ctrl;
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & s_reg.pready;
    assign do_write = access_done & pwrite & hit_any & ~s_reg.pslverr & pstrb[0];
    assign count_inc = s_reg.count_value + 8'h01;

    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_mode) begin
            read_word[`ART_MODE_RUN] = s_reg.run_enable;
            read_word[`ART_MODE_PRESC_HI:`ART_MODE_PRESC_LO] = s_reg.prescale_select;
            read_word[`ART_MODE_SINGLE] = s_reg.single_pulse_select;
            read_word[`ART_MODE_PWM_EN] = s_reg.pwm_output_enable;
        end else if (hit_count) begin
            read_word[7:0] = s_reg.count_value;
        end else if (hit_duty) begin
            read_word[7:0] = s_reg.duty_compare;
        end else if (hit_ctrl) begin
            read_word[`ART_CTRL_FLAG] = s_reg.overflow_flag;
            read_word[`ART_CTRL_IRQ_EN] = s_reg.overflow_irq_enable;
            read_word[`ART_CTRL_CLK_SEL] = s_reg.clock_source_select;
            read_word[`ART_CTRL_CHAN_HI:`ART_CTRL_CHAN_LO] = s_reg.pwm_channel_select;
        end
        // The reload register is write-only and reads as zero.
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        s_next = s_reg;
        overflow = 1'b0;
        flag_clear = 1'b0;

        // Bus phase tracking: ready is raised for exactly the first access cycle.
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        case (s_reg.phase)
            artpwm_pkg::APB_IDLE: begin
                if (setup_phase) begin
                    s_next.phase = artpwm_pkg::APB_ACCESS;
                    s_next.pready = 1'b1;
                    s_next.pslverr = ~hit_any;
                    s_next.prdata = pwrite ? 32'h0000_0000 : read_word;
                end
            end
            artpwm_pkg::APB_ACCESS: begin
                if (access_done) begin
                    s_next.phase = artpwm_pkg::APB_DONE;
                end else begin
                    s_next.pready = s_reg.pready;
                    s_next.pslverr = s_reg.pslverr;
                end
            end
            artpwm_pkg::APB_DONE: begin
                s_next.phase = artpwm_pkg::APB_IDLE;
                if (setup_phase) begin
                    s_next.phase = artpwm_pkg::APB_ACCESS;
                    s_next.pready = 1'b1;
                    s_next.pslverr = ~hit_any;
                    s_next.prdata = pwrite ? 32'h0000_0000 : read_word;
                end
            end
            default: begin
                s_next.phase = artpwm_pkg::APB_IDLE;
            end
        endcase

        // Timer core. Nothing here depends on a power mode, so it runs and raises
        // its flag in every mode and has no wake-up output at all.
        s_next.run_seen = s_reg.run_enable;
        // A stopped timer parks its level low, so a restart never shows the old level.
        if (!s_reg.run_enable) begin
            s_next.pwm_level = 1'b0;
        end
        if (s_reg.run_enable && !s_reg.run_seen) begin
            // Start of a run: buffers become active and the first period begins high when duty is above reload.
            s_next.reload_active = s_reg.reload_hold;
            s_next.duty_active = s_reg.duty_compare;
            s_next.pwm_level = (s_reg.duty_compare > s_reg.reload_hold);
        end else if (s_reg.run_enable && timer_tick) begin
            if (s_reg.count_value == `ART_COUNT_FULL) begin
                overflow = 1'b1;
                s_next.count_value = s_reg.reload_hold;
                s_next.reload_active = s_reg.reload_hold;
                s_next.duty_active = s_reg.duty_compare;
                s_next.pwm_level = (s_reg.duty_compare > s_reg.reload_hold);
                if (s_reg.single_pulse_select && s_reg.pwm_output_enable) begin
                    s_next.pwm_output_enable = 1'b0;
                end
            end else begin
                s_next.count_value = count_inc;
                if (count_inc == s_reg.duty_active) begin
                    s_next.pwm_level = 1'b0;
                end
            end
        end

        // Software writes land after the timer update, so a write in the same cycle
        // wins over counting or the single-pulse self-clear.
        if (do_write) begin
            if (hit_mode) begin
                s_next.run_enable = pwdata[`ART_MODE_RUN];
                s_next.prescale_select = pwdata[`ART_MODE_PRESC_HI:`ART_MODE_PRESC_LO];
                s_next.single_pulse_select = pwdata[`ART_MODE_SINGLE];
                s_next.pwm_output_enable = pwdata[`ART_MODE_PWM_EN];
            end
            if (hit_count) begin
                s_next.count_value = pwdata[7:0];
            end
            if (hit_reload) begin
                s_next.reload_hold = pwdata[7:0];
            end
            if (hit_duty) begin
                s_next.duty_compare = pwdata[7:0];
            end
            if (hit_ctrl) begin
                flag_clear = pwdata[`ART_CTRL_FLAG];
                s_next.overflow_irq_enable = pwdata[`ART_CTRL_IRQ_EN];
                s_next.clock_source_select = pwdata[`ART_CTRL_CLK_SEL];
                s_next.pwm_channel_select = pwdata[`ART_CTRL_CHAN_HI:`ART_CTRL_CHAN_LO];
            end
        end

        // An overflow in the same cycle as the clear keeps the flag set.
        s_next.overflow_flag = (s_reg.overflow_flag & ~flag_clear) | overflow;

        // The request level stands while the flag and its enable are both set; the
        // core vectors to `ART_IRQ_VECTOR on it.
        s_next.irq_request = s_next.overflow_flag & s_next.overflow_irq_enable;
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.phase <= artpwm_pkg::APB_IDLE;
            s_reg.count_value <= `ART_COUNT_RESET;
            s_reg.reload_hold <= `ART_COUNT_RESET;
            s_reg.reload_active <= `ART_COUNT_RESET;
            s_reg.duty_compare <= `ART_COUNT_RESET;
            s_reg.duty_active <= `ART_COUNT_RESET;
            s_reg.pwm_channel_select <= `ART_GPIO_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign irq_request = s_reg.irq_request;

endmodule

// >>> tb/artpwm_chk.sv
`timescale 1ns/1ps
`include "artpwm_cfg.svh"

module artpwm_chk #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] pwm_pin_out,
    input wire logic [1:0] pwm_pin_active,
    input wire logic irq_request
);
    logic bad;
    logic ctl_wr;
    // Four timer words plus the control word are mapped; everything else is refused.
    assign bad = (paddr[1:0] != 2'h0) || (paddr[ADDR_WIDTH-1:2] < `ART_IDX_MODE)
        || (paddr[ADDR_WIDTH-1:2] > `ART_IDX_CTRL);
    assign ctl_wr = psel && penable && pready && pwrite && pstrb[0] && !bad
        && (paddr[ADDR_WIDTH-1:2] == `ART_IDX_CTRL);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_setup; psel && !penable; endsequence
    sequence s_done; psel && penable && pready; endsequence
    property p_ready; s_setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no pready after setup");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready held too long");
    property p_ready_acc; pready |-> psel && penable; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("pready outside access");
    property p_err; s_setup |=> pslverr == $past(bad); endproperty
    a_err: assert property (p_err) else $error("wrong error response");
    property p_err_data; s_done ##0 (pslverr && !pwrite) |-> prdata == 32'h0; endproperty
    a_err_data: assert property (p_err_data) else $error("refused read not zero");
    property p_upper; s_done |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_gpio;
        (pwm_pin_out & ~pwm_pin_active) == ($past(gpio_out) & ~pwm_pin_active);
    endproperty
    a_gpio: assert property (p_gpio) else $error("idle pin not gpio");
    property p_irq_fall; $fell(irq_request) |-> $past(ctl_wr); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    property p_irq_off; ctl_wr && !pwdata[`ART_CTRL_IRQ_EN] |=> !irq_request; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
endmodule

// >>> tb/artpwm_test.sv
`timescale 1ns/1ps

module artpwm_test;
    localparam logic [11:0] AMOD = 12'h280, ACNT = 12'h284, ARLD = 12'h288;
    localparam logic [11:0] ADTY = 12'h28C, ACTL = 12'h290;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hosc_tick = 1'b0, losc_tick = 1'b0, pready, pslverr, irq_request;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic [2:0] tcnt = 3'h0;
    logic [1:0] gpio_out = 2'h0, pwm_pin_out, pwm_pin_active;
    int mismatches = 0, num_checks = 0, hi, lo, k;

    artpwm_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hosc_tick(hosc_tick), .losc_tick(losc_tick), .gpio_out(gpio_out),
        .pwm_pin_out(pwm_pin_out), .pwm_pin_active(pwm_pin_active), .irq_request(irq_request)
    );

    always #2.5 pclk = ~pclk;

    // Fast source ticks every second cycle, slow source every eighth.
    always @(posedge pclk) begin
        tcnt <= tcnt + 3'h1;
        hosc_tick <= tcnt[0];
        losc_tick <= (tcnt == 3'h7);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        mismatches += (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps back-to-back calls from assigning psel twice.
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task automatic rd(input string n, input logic [11:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(n, {24'h0, x}, r);
    endtask

    task automatic cfg(input logic [7:0] m, input logic [7:0] r, input logic [7:0] d,
        input logic [7:0] c);
        wr(AMOD, 8'h00);
        wr(ACTL, c | 8'h01);
        wr(ACNT, r);
        wr(ARLD, r);
        wr(ADTY, d);
        wr(AMOD, m & 8'h7F);
        wr(AMOD, m);
    endtask

    task automatic wait_pin(input logic v);
        int n;
        n = 0;
        while (pwm_pin_out[0] !== v && n < 5000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic measure();
        hi = 0;
        lo = 0;
        while (pwm_pin_out[0] === 1'b1 && hi < 5000) begin
            @(posedge pclk);
            hi++;
        end
        while (pwm_pin_out[0] === 1'b0 && lo < 5000) begin
            @(posedge pclk);
            lo++;
        end
    endtask

    // The first period after enable is skipped, since the source tick phase may trim it.
    task automatic period();
        wait_pin(1'b1);
        wait_pin(1'b0);
        wait_pin(1'b1);
        measure();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd("mode", AMOD, 8'h00);
        rd("count", ACNT, 8'h00);
        rd("duty", ADTY, 8'h00);
        rd("ctrl", ACTL, 8'h00);
        wr(ADTY, 8'h5A);
        rd("duty rw", ADTY, 8'h5A);
        pstrb <= 4'hE;
        wr(ADTY, 8'hA5);
        pstrb <= 4'hF;
        rd("strobe off", ADTY, 8'h5A);
        wr(ARLD, 8'h33);
        rd("reload wo", ARLD, 8'h00);
        apb(1'b0, 12'h2A0, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        apb(1'b1, 12'h281, 32'h7, r, e);
        chk("unaligned err", 32'h1, {31'h0, e});
        wr(ACNT, 8'h10);
        repeat (40) @(posedge pclk);
        rd("held count", ACNT, 8'h10);
    endtask

    task automatic t_pwm();
        gpio_out <= 2'b10;
        cfg(8'hF1, 8'hF0, 8'hF4, 8'h10);
        period();
        chk("high", 32'd8, hi);
        chk("low", 32'd24, lo);
        chk("active", 32'h1, {30'h0, pwm_pin_active});
        fork
            measure();
            wr(ARLD, 8'hE0);
        join
        chk("old period", 32'd32, hi + lo);
        measure();
        chk("new high", 32'd40, hi);
        chk("new low", 32'd24, lo);
        wr(AMOD, 8'hF0);
        repeat (3) @(posedge pclk);
        chk("pwm off", 32'h2, {30'h0, pwm_pin_out});
        cfg(8'hF1, 8'hF0, 8'hF4, 8'h00);
        repeat (40) @(posedge pclk);
        chk("no channel", 32'h0, {30'h0, pwm_pin_active});
        cfg(8'hF1, 8'hF0, 8'hF0, 8'h10);
        hi = 0;
        repeat (80) begin
            @(posedge pclk);
            hi += (pwm_pin_out[0] !== 1'b0);
        end
        chk("duty low", 32'h0, hi);
    endtask

    task automatic t_presc();
        for (k = 0; k < 8; k++) begin
            cfg({1'b1, k[2:0], 4'h1}, 8'hFC, 8'hFE, 8'h10);
            period();
            chk("scaled high", 32'd4 << (7 - k), hi);
            chk("scaled low", 32'd4 << (7 - k), lo);
        end
        cfg(8'hF1, 8'hFC, 8'hFE, 8'h14);
        period();
        chk("slow high", 32'd16, hi);
    endtask

    task automatic t_single();
        logic pv;
        gpio_out <= 2'b00;
        cfg(8'hF3, 8'hFC, 8'hFE, 8'h10);
        lo = 0;
        pv = pwm_pin_out[0];
        repeat (200) begin
            @(posedge pclk);
            lo += (pv === 1'b1 && pwm_pin_out[0] === 1'b0);
            pv = pwm_pin_out[0];
        end
        chk("pulses", 32'h1, lo);
        chk("released", 32'h0, {30'h0, pwm_pin_active});
        rd("mode cleared", AMOD, 8'hF2);
    endtask

    task automatic t_flag();
        cfg(8'hF0, 8'hFE, 8'hFF, 8'h02);
        k = 0;
        while (irq_request !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk("irq", 32'h1, {31'h0, irq_request});
        wr(AMOD, 8'h00);
        rd("flag", ACTL, 8'h03);
        repeat (20) @(posedge pclk);
        rd("flag held", ACTL, 8'h03);
        wr(ACTL, 8'h03);
        rd("flag clear", ACTL, 8'h02);
        chk("irq off", 32'h0, {31'h0, irq_request});
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pwm();
        t_presc();
        t_single();
        t_flag();
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        finish_test();
    end
endmodule

bind artpwm_top artpwm_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_out(gpio_out), .pwm_pin_out(pwm_pin_out),
    .pwm_pin_active(pwm_pin_active), .irq_request(irq_request)
);
